/* src/dcr_pkg.sv */
// Purpose: shared constants and types of the drive communication register bank
// Assumes: one register per request, already split out of the serial frame
// Notes:   offsets are register numbers as they travel on the bus
package dcr_pkg;
   // function codes and exception answers
   localparam logic [7:0]  FC_RD_BITS     = 8'h02;
   localparam logic [7:0]  FC_RD_HOLD     = 8'h03;
   localparam logic [7:0]  FC_RD_INPUT    = 8'h04;
   localparam logic [7:0]  FC_WR_SINGLE   = 8'h06;
   localparam logic [7:0]  EXC_NONE       = 8'h00;
   localparam logic [7:0]  EXC_FUNC       = 8'h01;
   localparam logic [7:0]  EXC_ADDR       = 8'h02;
   localparam logic [7:0]  EXC_VALUE      = 8'h03;
   localparam logic [7:0]  EXC_BUSY       = 8'h06;
   // register offsets
   localparam logic [15:0] OFS_VIRT_IN    = 16'h0019;
   localparam logic [15:0] OFS_TORQUE     = 16'h001A;
   localparam logic [15:0] OFS_SPD_LIMIT  = 16'h001B;
   localparam logic [15:0] OFS_PAR_UPDATE = 16'h0069;
   localparam logic [15:0] OFS_PAR_BASE   = 16'h006A;
   localparam logic [15:0] OFS_TGT_RSVD   = 16'h0472;
   localparam logic [15:0] OFS_STATUS     = 16'h0470;
   localparam logic [15:0] OFS_DETECT     = 16'h0471;
   // bit address of a monitoring bit = register offset * 16 + bit
   localparam logic [11:0] BIT_AREA_HI    = 12'h470;
   localparam logic [11:0] BIT_AREA_HI2   = 12'h471;
   // value limits and update codes
   localparam logic signed [15:0] TORQUE_MIN = -16'sd1000;
   localparam logic signed [15:0] TORQUE_MAX = 16'sd1000;
   localparam logic [15:0] SPD_LIMIT_MAX  = 16'd40000;
   localparam logic [15:0] UPD_NONE       = 16'h0000;
   localparam logic [15:0] UPD_IMAGE      = 16'h0055;
   localparam logic [15:0] UPD_FACTORY    = 16'h00AA;
   localparam logic [7:0]  VIRT_MASK      = 8'hFF;
   // broadcast running-signal word bits
   localparam int BC_FWD    = 10;
   localparam int BC_REV    = 11;
   localparam int BC_RUN    = 12;
   localparam int BC_EXTF   = 13;
   localparam int BC_FRESET = 14;
   // percentage thresholds for the detection word
   localparam logic [7:0]  PCT_BUS_V      = 8'd85;
   localparam logic [7:0]  PCT_CUR_RUN    = 8'd5;
   localparam logic [7:0]  PCT_CUR_STOP   = 8'd10;
   localparam logic [7:0]  PCT_FULL       = 8'd100;
   // reset values
   localparam logic [7:0]  RST_VIRT       = 8'h00;
   localparam logic [15:0] RST_TORQUE     = 16'h0000;
   localparam logic [15:0] RST_SPD_LIMIT  = 16'h0000;

   typedef enum logic [1:0] {UPD_IDLE, UPD_COPY, UPD_FACT} dcr_upd_state_t;

   // drive state flags feeding the status word
   typedef struct packed {
      logic running;
      logic in_service;
      logic zero_speed;
      logic forward;
      logic power_ok;
      logic lockout;
      logic fault;
      logic tuning;
      logic tune_req;
   } dcr_drive_sts_t;

   // measurements and flags feeding the detection word
   typedef struct packed {
      logic [15:0] out_freq;
      logic [15:0] detect_freq;
      logic [15:0] set_freq;
      logic [15:0] fb_freq;
      logic [15:0] band;
      logic [15:0] bus_volt;
      logic [15:0] rated_volt;
      logic [15:0] current;
      logic [15:0] rated_cur;
      logic        speed_arrive;
      logic        over_torque;
      logic        under_volt;
      logic        fault_warn;
   } dcr_detect_in_t;

   // decoded broadcast commands
   typedef struct packed {
      logic forward_command;
      logic reverse_command;
      logic run;
      logic ext_fault;
      logic fault_reset;
   } dcr_bcast_cmd_t;
endpackage

/* src/dcr_mem.sv */
// Purpose: small parameter memory, one write port and one registered read port
// Assumes: read data appear one edge after the address
// Notes:   array has no reset; each entry is defined only once it has been written
`timescale 1ns/1ps
module dcr_mem #(
   parameter int W = 16,
   parameter int D = 16,
   parameter int A = 4
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         wr_en,
   input  wire logic [A-1:0] wr_addr,
   input  wire logic [W-1:0] wr_data,
   input  wire logic [A-1:0] rd_addr,
   output logic      [W-1:0] rd_data_r
);
   logic [W-1:0] mem [D];
   logic [W-1:0] rd_nxt;

   always_comb begin
      rd_nxt = mem[rd_addr];
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= rd_nxt;
      end
   end
endmodule

/* src/dcr_regs.sv */
// Purpose: communication register bank of the drive (setpoints, update, status)
// Assumes: frame engine hands over one register access per request pulse
// Notes:   answer comes one edge after the request; parameter area is write-only
`timescale 1ns/1ps
// Function
// - adopted input = broadcast bit and validity bit, ored with real input
// - broadcast word bit 14 commands fault reset; bit 15 unused
// - virtual input register bits 0..7 drive virtual terminals 0..7; rest reserved
// - effective terminal = virtual bit ored with external terminal level
// - torque setpoint accepts -1000..1000 in 0.1 percent steps
// - speed limit accepts 0..40000 in 0.01 Hz steps
// - bus parameter writes go to image store, not working parameters
// - writing 0x55 copies image store into working parameters
// - writing 0xAA loads factory defaults into working parameters
// - zero means no update; register clears itself after each update
// - status word bits 0..5 show run, service, zero speed, direction, power, lockout
// - status word bit 7 fault, bit 10 tuning, bit 11 tuning requested
// - detection bit 0 freq at/below, bit 1 at/above detection frequency
// - detection bit 2 setpoint and feedback in band, bit 3 speed reached
// - detection bits 5 over-torque, 6 undervoltage, 7 bus above 85 percent
// - detection bit 8 current over 5 percent running, 10 percent stopped
// - detection bit 9 fault warning; bits 10..15 read zero
// - broadcast bits 10 forward, 11 reverse, 12 run, 13 external fault
module dcr_regs
   import dcr_pkg::*;
#(
   parameter int          PAR_DEPTH   = 16,
   parameter int          PAR_AW      = 4,
   parameter logic [15:0] FACTORY_VAL = 16'h0000
) (
   input  wire logic                  core_clk,
   input  wire logic                  resetn,
   input  wire logic                  req_valid,
   input  wire logic [7:0]            req_func,
   input  wire logic [15:0]           req_addr,
   input  wire logic [15:0]           req_wdata,
   output logic                       resp_valid_r,
   output logic      [15:0]           resp_rdata_r,
   output logic      [7:0]            resp_exc_r,
   input  wire logic [15:0]           bcast_word,
   input  wire logic [7:0]            bcast_valid,
   input  wire logic [7:0]            func_in,
   output logic      [7:0]            adopted_in_r,
   output dcr_pkg::dcr_bcast_cmd_t    bcast_cmd_r,
   input  wire logic [7:0]            ext_term,
   output logic      [7:0]            term_in_r,
   output logic      [15:0]           torque_sp_r,
   output logic      [15:0]           spd_limit_r,
   input  wire dcr_pkg::dcr_drive_sts_t drive_sts,
   input  wire dcr_pkg::dcr_detect_in_t det_in,
   input  wire logic [PAR_AW-1:0]     par_rd_addr,
   output logic      [15:0]           par_rd_data_r,
   output logic                       upd_busy
);
   import dcr_pkg::*;

   logic [7:0]            virt_r, virt_nxt;
   logic [15:0]           torque_nxt, spd_nxt;
   logic [15:0]           upd_cmd_r, upd_cmd_nxt;
   logic                  resp_valid_nxt;
   logic [15:0]           resp_rdata_nxt;
   logic [7:0]            resp_exc_nxt;
   dcr_upd_state_t        st_r, st_nxt;
   logic [PAR_AW-1:0]     idx_r, idx_nxt, wr_idx_r, wr_idx_nxt;
   logic                  pend_r, pend_nxt;
   logic                  img_we, work_we;
   logic [PAR_AW-1:0]     img_wa, work_wa;
   logic [15:0]           img_rd, work_wd;
   logic [15:0]           sts_word, det_word;
   logic                  is_wr, in_par;
   logic [15:0]           par_ofs;
   logic [31:0]           bus_lhs, bus_rhs, cur_lhs, cur_rhs;

   assign upd_busy = (st_r != UPD_IDLE);
   assign is_wr    = req_valid && (req_func == FC_WR_SINGLE);
   assign par_ofs  = req_addr - OFS_PAR_BASE;
   assign in_par   = (req_addr >= OFS_PAR_BASE) && (par_ofs < 16'(PAR_DEPTH));

   // monitoring words
   always_comb begin
      sts_word     = '0;
      sts_word[0]  = drive_sts.running;
      sts_word[1]  = drive_sts.in_service;
      sts_word[2]  = drive_sts.zero_speed;
      sts_word[3]  = drive_sts.forward;
      sts_word[4]  = drive_sts.power_ok;
      sts_word[5]  = drive_sts.lockout;
      sts_word[7]  = drive_sts.fault;
      sts_word[10] = drive_sts.tuning;
      sts_word[11] = drive_sts.tune_req;
   end

   // widened products so percentage compares never overflow
   assign bus_lhs = {16'h0000, det_in.bus_volt} * {24'h0, PCT_FULL};
   assign bus_rhs = {16'h0000, det_in.rated_volt} * {24'h0, PCT_BUS_V};
   assign cur_lhs = {16'h0000, det_in.current} * {24'h0, PCT_FULL};
   assign cur_rhs = {16'h0000, det_in.rated_cur}
                  * {24'h0, drive_sts.running ? PCT_CUR_RUN : PCT_CUR_STOP};

   always_comb begin
      det_word    = '0;
      det_word[0] = det_in.out_freq <= det_in.detect_freq;
      det_word[1] = det_in.out_freq >= det_in.detect_freq;
      det_word[2] = ((det_in.set_freq >= det_in.fb_freq)
                     ? (det_in.set_freq - det_in.fb_freq)
                     : (det_in.fb_freq - det_in.set_freq)) <= det_in.band;
      det_word[3] = det_in.speed_arrive;
      det_word[5] = det_in.over_torque;
      det_word[6] = det_in.under_volt;
      det_word[7] = bus_lhs > bus_rhs;
      det_word[8] = cur_lhs > cur_rhs;
      det_word[9] = det_in.fault_warn;
   end

   // request decode and answer
   always_comb begin
      virt_nxt       = virt_r;
      torque_nxt     = torque_sp_r;
      spd_nxt        = spd_limit_r;
      upd_cmd_nxt    = upd_cmd_r;
      resp_valid_nxt = req_valid;
      resp_rdata_nxt = '0;
      resp_exc_nxt   = EXC_NONE;
      img_we         = 1'b0;
      img_wa         = par_ofs[PAR_AW-1:0];
      if (req_valid) begin
         unique case (req_func)
            FC_RD_HOLD: begin
               if (req_addr == OFS_VIRT_IN) begin
                  resp_rdata_nxt = {8'h00, virt_r};
               end else if (req_addr == OFS_TORQUE) begin
                  resp_rdata_nxt = torque_sp_r;
               end else if (req_addr == OFS_SPD_LIMIT) begin
                  resp_rdata_nxt = spd_limit_r;
               end else if (req_addr == OFS_PAR_UPDATE) begin
                  resp_rdata_nxt = upd_cmd_r;
               end else begin
                  resp_exc_nxt = EXC_ADDR;
               end
            end
            FC_RD_INPUT: begin
               if (req_addr == OFS_STATUS) begin
                  resp_rdata_nxt = sts_word;
               end else if (req_addr == OFS_DETECT) begin
                  resp_rdata_nxt = det_word;
               end else begin
                  resp_exc_nxt = EXC_ADDR;
               end
            end
            FC_RD_BITS: begin
               if (req_addr[15:4] == BIT_AREA_HI) begin
                  resp_rdata_nxt = {15'h0, sts_word[req_addr[3:0]]};
               end else if (req_addr[15:4] == BIT_AREA_HI2) begin
                  resp_rdata_nxt = {15'h0, det_word[req_addr[3:0]]};
               end else begin
                  resp_exc_nxt = EXC_ADDR;
               end
            end
            FC_WR_SINGLE: begin
               resp_rdata_nxt = req_wdata;
               if (req_addr == OFS_VIRT_IN) begin
                  virt_nxt = req_wdata[7:0] & VIRT_MASK;
               end else if (req_addr == OFS_TORQUE) begin
                  if ($signed(req_wdata) >= TORQUE_MIN
                      && $signed(req_wdata) <= TORQUE_MAX) begin
                     torque_nxt = req_wdata;
                  end else begin
                     resp_exc_nxt = EXC_VALUE;
                  end
               end else if (req_addr == OFS_SPD_LIMIT) begin
                  if (req_wdata <= SPD_LIMIT_MAX) begin
                     spd_nxt = req_wdata;
                  end else begin
                     resp_exc_nxt = EXC_VALUE;
                  end
               end else if (req_addr == OFS_PAR_UPDATE) begin
                  if (upd_busy) begin
                     resp_exc_nxt = EXC_BUSY;
                  end else begin
                     upd_cmd_nxt = req_wdata;
                  end
               end else if (in_par) begin
                  // image writes are held off while any update runs, copy or factory fill
                  if (upd_busy) begin
                     resp_exc_nxt = EXC_BUSY;
                  end else begin
                     img_we = 1'b1;
                  end
               end else begin
                  resp_exc_nxt = EXC_ADDR;
               end
            end
            default: begin
               resp_exc_nxt = EXC_FUNC;
            end
         endcase
      end
      // update engine finished: the command register returns to zero
      if (upd_busy && st_nxt == UPD_IDLE) begin
         upd_cmd_nxt = UPD_NONE;
      end else if (!upd_busy && upd_cmd_r != UPD_NONE && upd_cmd_r != UPD_IMAGE
                   && upd_cmd_r != UPD_FACTORY && !is_wr) begin
         upd_cmd_nxt = UPD_NONE;
      end
   end

   // update engine: walks every parameter entry, one per edge
   always_comb begin
      st_nxt     = st_r;
      idx_nxt    = idx_r;
      wr_idx_nxt = idx_r;
      pend_nxt   = 1'b0;
      work_we    = 1'b0;
      work_wa    = wr_idx_r;
      work_wd    = img_rd;
      unique case (st_r)
         UPD_IDLE: begin
            idx_nxt = '0;
            if (upd_cmd_r == UPD_IMAGE) begin
               st_nxt = UPD_COPY;
            end else if (upd_cmd_r == UPD_FACTORY) begin
               st_nxt = UPD_FACT;
            end
         end
         UPD_COPY: begin
            // image read lags the address by one edge
            work_we = pend_r;
            if (idx_r == PAR_AW'(PAR_DEPTH - 1) && pend_r && wr_idx_r == idx_r) begin
               st_nxt = UPD_IDLE;
            end else begin
               pend_nxt = 1'b1;
               if (idx_r != PAR_AW'(PAR_DEPTH - 1)) begin
                  idx_nxt = idx_r + PAR_AW'(1);
               end
            end
         end
         UPD_FACT: begin
            work_we = 1'b1;
            work_wa = idx_r;
            work_wd = FACTORY_VAL;
            if (idx_r == PAR_AW'(PAR_DEPTH - 1)) begin
               st_nxt = UPD_IDLE;
            end else begin
               idx_nxt = idx_r + PAR_AW'(1);
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         virt_r       <= RST_VIRT;
         torque_sp_r  <= RST_TORQUE;
         spd_limit_r  <= RST_SPD_LIMIT;
         upd_cmd_r    <= UPD_NONE;
         resp_valid_r <= 1'b0;
         resp_rdata_r <= '0;
         resp_exc_r   <= EXC_NONE;
         st_r         <= UPD_IDLE;
         idx_r        <= '0;
         wr_idx_r     <= '0;
         pend_r       <= 1'b0;
         adopted_in_r <= '0;
         term_in_r    <= '0;
         bcast_cmd_r  <= '0;
      end else begin
         virt_r       <= virt_nxt;
         torque_sp_r  <= torque_nxt;
         spd_limit_r  <= spd_nxt;
         upd_cmd_r    <= upd_cmd_nxt;
         resp_valid_r <= resp_valid_nxt;
         resp_rdata_r <= resp_rdata_nxt;
         resp_exc_r   <= resp_exc_nxt;
         st_r         <= st_nxt;
         idx_r        <= idx_nxt;
         wr_idx_r     <= wr_idx_nxt;
         pend_r       <= pend_nxt;
         adopted_in_r <= (bcast_word[7:0] & bcast_valid) | func_in;
         term_in_r    <= virt_r | ext_term;
         bcast_cmd_r  <= '{forward_command: bcast_word[BC_FWD],
                           reverse_command: bcast_word[BC_REV],
                           run:             bcast_word[BC_RUN],
                           ext_fault:       bcast_word[BC_EXTF],
                           fault_reset:     bcast_word[BC_FRESET]};
      end
   end

   // image store: written by the bus, read only by the update engine
   dcr_mem #(.W(16), .D(PAR_DEPTH), .A(PAR_AW)) u_image (
      .clk       (core_clk),
      .resetn    (resetn),
      .wr_en     (img_we),
      .wr_addr   (img_wa),
      .wr_data   (req_wdata),
      .rd_addr   (idx_r),
      .rd_data_r (img_rd)
   );

   // working parameters: written only by the update engine
   dcr_mem #(.W(16), .D(PAR_DEPTH), .A(PAR_AW)) u_work (
      .clk       (core_clk),
      .resetn    (resetn),
      .wr_en     (work_we),
      .wr_addr   (work_wa),
      .wr_data   (work_wd),
      .rd_addr   (par_rd_addr),
      .rd_data_r (par_rd_data_r)
   );

   property p_adopt;
      @(posedge core_clk) disable iff (!resetn)
      1'b1 |=> adopted_in_r == (($past(bcast_word[7:0]) & $past(bcast_valid)) | $past(func_in));
   endproperty
   a_adopt: assert property (p_adopt) else $error("adopted input mismatch");

   property p_freset;
      @(posedge core_clk) disable iff (!resetn)
      bcast_word[BC_FRESET] |=> bcast_cmd_r.fault_reset;
   endproperty
   a_freset: assert property (p_freset) else $error("fault reset not decoded");

   property p_term;
      @(posedge core_clk) disable iff (!resetn)
      1'b1 |=> term_in_r == ($past(virt_r) | $past(ext_term));
   endproperty
   a_term: assert property (p_term) else $error("external terminal lost");

   property p_torque_range;
      @(posedge core_clk) disable iff (!resetn)
      is_wr && req_addr == OFS_TORQUE && $signed(req_wdata) > TORQUE_MAX
      |=> $stable(torque_sp_r) && resp_exc_r == EXC_VALUE;
   endproperty
   a_torque_range: assert property (p_torque_range) else $error("torque out of range taken");

   property p_spd_range;
      @(posedge core_clk) disable iff (!resetn)
      is_wr && req_addr == OFS_SPD_LIMIT && req_wdata > SPD_LIMIT_MAX |=> $stable(spd_limit_r);
   endproperty
   a_spd_range: assert property (p_spd_range) else $error("speed limit out of range taken");

   property p_work_only_engine;
      @(posedge core_clk) disable iff (!resetn)
      !upd_busy |-> !work_we;
   endproperty
   a_work_only_engine: assert property (p_work_only_engine) else $error("working write idle");

   property p_upd_done;
      @(posedge core_clk) disable iff (!resetn)
      !upd_busy && (upd_cmd_r == UPD_IMAGE || upd_cmd_r == UPD_FACTORY)
      |=> upd_busy ##[1:40] (upd_cmd_r == UPD_NONE && !upd_busy);
   endproperty
   a_upd_done: assert property (p_upd_done) else $error("update did not finish and clear");

   property p_bad_code;
      @(posedge core_clk) disable iff (!resetn)
      !upd_busy && upd_cmd_r != UPD_NONE && upd_cmd_r != UPD_IMAGE
      && upd_cmd_r != UPD_FACTORY && !is_wr |=> upd_cmd_r == UPD_NONE && !upd_busy;
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("undefined code not dropped");

   property p_det_zero;
      @(posedge core_clk) disable iff (!resetn)
      req_valid && req_func == FC_RD_INPUT && req_addr == OFS_DETECT
      |=> resp_rdata_r[15:10] == 6'h00 && resp_rdata_r[9] == $past(det_in.fault_warn);
   endproperty
   a_det_zero: assert property (p_det_zero) else $error("detection upper bits wrong");
endmodule

/* tb/dcr_master.sv */
// Purpose: bus master model, one register access per call
// Assumes: answer comes one edge after the request is taken
// Notes:   released address and data lines show the inverse; the function code keeps its old value
`timescale 1ns/1ps
module dcr_master (
   input  wire logic        core_clk,
   output logic             req_valid,
   output logic [7:0]       req_func,
   output logic [15:0]      req_addr,
   output logic [15:0]      req_wdata,
   input  wire logic        resp_valid_r,
   input  wire logic [15:0] resp_rdata_r,
   input  wire logic [7:0]  resp_exc_r
);
   initial begin
      req_valid = 1'b0;
      req_func  = 8'h00;
      req_addr  = 16'h0000;
      req_wdata = 16'h0000;
   end
   // input words are read with code 04, holding words with code 03, and single bits with code 02
   task automatic access(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                         output logic [15:0] rd, output logic [7:0] exc);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_func  <= f;
      req_addr  <= a;
      req_wdata <= d;
      @(posedge core_clk);
      req_valid <= 1'b0;
      req_addr  <= ~a;
      req_wdata <= ~d;
      #1;
      rd  = resp_rdata_r;
      exc = (resp_valid_r === 1'b1) ? resp_exc_r : 8'hEE;
   endtask
endmodule

/* tb/dcr_regs_tb.sv */
// Purpose: self-checking bench of the drive communication register bank
// Assumes: one access at a time through the master model
// Notes:   working memory is only defined after the first update
`timescale 1ns/1ps
module dcr_regs_tb;
   import dcr_pkg::*;
   logic           core_clk = 1'b0;
   logic           resetn = 1'b0;
   logic           req_valid, resp_valid_r, upd_busy;
   logic [7:0]     req_func, resp_exc_r, adopted_in_r, term_in_r;
   logic [15:0]    req_addr, req_wdata, resp_rdata_r, torque_sp_r, spd_limit_r, par_rd_data_r;
   logic [15:0]    bcast_word = 16'h0000;
   logic [7:0]     bcast_valid = 8'h00, func_in = 8'h00, ext_term = 8'h00;
   logic [3:0]     par_rd_addr = 4'h0;
   dcr_bcast_cmd_t bcast_cmd_r;
   dcr_drive_sts_t drive_sts = '0;
   dcr_detect_in_t det_in = '0;
   int             errors = 0, comparisons = 0;
   always #20 core_clk = ~core_clk;
   dcr_master i_dcr_master (.core_clk, .req_valid, .req_func, .req_addr, .req_wdata,
      .resp_valid_r, .resp_rdata_r, .resp_exc_r);
   dcr_regs i_dcr_regs (.core_clk, .resetn, .req_valid, .req_func, .req_addr, .req_wdata,
      .resp_valid_r, .resp_rdata_r, .resp_exc_r, .bcast_word, .bcast_valid, .func_in,
      .adopted_in_r, .bcast_cmd_r, .ext_term, .term_in_r, .torque_sp_r, .spd_limit_r,
      .drive_sts, .det_in, .par_rd_addr, .par_rd_data_r, .upd_busy);
   task automatic end_sim;
      if (errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask
   task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      input logic [15:0] erd, input logic [7:0] eexc);
      logic [15:0] rd;
      logic [7:0]  exc;
      i_dcr_master.access(f, a, d, rd, exc);
      check(16'(exc), 16'(eexc), "exception code");
      if (eexc == EXC_NONE)
         check(rd, erd, "read data");
   endtask
   task automatic par(input logic [3:0] i, input logic [15:0] e);
      @(posedge core_clk);
      par_rd_addr <= i;
      repeat (2) @(posedge core_clk);
      #1;
      check(par_rd_data_r, e, "working parameter");
   endtask
   // a code that starts no walk must still read back as zero afterwards
   task automatic upd(input logic [15:0] code);
      int n;
      acc(FC_WR_SINGLE, OFS_PAR_UPDATE, code, code, EXC_NONE);
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (upd_busy !== 1'b0 && n < 40);
      if (n >= 40) begin
         errors++;
         end_sim();
      end
      acc(FC_RD_HOLD, OFS_PAR_UPDATE, 16'h0000, UPD_NONE, EXC_NONE);
   endtask
   initial begin
      #(40 * 20000);
      errors++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      check(torque_sp_r, 16'h0000, "torque after reset");
      check(spd_limit_r, 16'h0000, "limit after reset");
      acc(FC_WR_SINGLE, OFS_TORQUE, 16'h03E8, 16'h03E8, EXC_NONE);
      acc(FC_WR_SINGLE, OFS_TORQUE, 16'hFC17, 16'h0000, EXC_VALUE);
      check(torque_sp_r, 16'h03E8, "torque kept");
      acc(FC_WR_SINGLE, OFS_TORQUE, 16'hFC18, 16'hFC18, EXC_NONE);
      acc(FC_WR_SINGLE, OFS_TORQUE, 16'h03E9, 16'h0000, EXC_VALUE);
      check(torque_sp_r, 16'hFC18, "torque kept");
      acc(FC_WR_SINGLE, OFS_SPD_LIMIT, 16'h9C40, 16'h9C40, EXC_NONE);
      acc(FC_WR_SINGLE, OFS_SPD_LIMIT, 16'h9C41, 16'h0000, EXC_VALUE);
      check(spd_limit_r, 16'h9C40, "limit kept");
      ext_term <= 8'h0A;
      bcast_word <= 16'hCCF0;
      bcast_valid <= 8'h3C;
      func_in <= 8'h01;
      drive_sts <= 9'h155;
      det_in <= {16'd100, 16'd100, 16'd50, 16'd55, 16'd5, 16'd86, 16'd100, 16'd6, 16'd100,
                 4'b1101};
      acc(FC_WR_SINGLE, OFS_VIRT_IN, 16'hFFA5, 16'hFFA5, EXC_NONE);
      acc(FC_RD_HOLD, OFS_VIRT_IN, 16'h0000, 16'h00A5, EXC_NONE);
      check(16'(term_in_r), 16'h00AF, "terminals");
      check(16'(adopted_in_r), 16'h0031, "adopted inputs");
      check(16'(bcast_cmd_r), 16'h0019, "broadcast commands");
      acc(FC_RD_INPUT, OFS_STATUS, 16'h0000, 16'h0895, EXC_NONE);
      acc(FC_RD_BITS, 16'h4707, 16'h0000, 16'h0001, EXC_NONE);
      acc(FC_RD_BITS, 16'h4701, 16'h0000, 16'h0000, EXC_NONE);
      acc(FC_RD_INPUT, OFS_DETECT, 16'h0000, 16'h03AF, EXC_NONE);
      acc(FC_RD_INPUT, OFS_TGT_RSVD, 16'h0000, 16'h0000, EXC_ADDR);
      acc(8'h10, OFS_TORQUE, 16'h0000, 16'h0000, EXC_FUNC);
      upd(UPD_FACTORY);
      par(4'h3, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         acc(FC_WR_SINGLE, OFS_PAR_BASE + 16'(i), 16'h1000 + 16'(i), 16'h1000 + 16'(i), EXC_NONE);
      end
      par(4'h3, 16'h0000);
      upd(16'h0033);
      par(4'h3, 16'h0000);
      upd(UPD_IMAGE);
      par(4'h0, 16'h1000);
      par(4'h3, 16'h1003);
      par(4'hF, 16'h100F);
      upd(UPD_FACTORY);
      par(4'h3, 16'h0000);
      end_sim();
   end
endmodule
